// ---- src/mmm_master.sv ----
`timescale 1ns/10ps
`include "mmm_params.svh"
module mmm_master
    import mmm_pkg::*;
#(
    parameter int AW          = `MMM_ADDR_W,
    parameter int SYMW        = `MMM_SYMBOL_W,
    parameter int NSYM        = `MMM_NUM_SYMBOLS,
    parameter int BW          = `MMM_BURST_W,
    parameter int RSW         = `MMM_RESP_W,
    parameter int WSW         = `MMM_RESP_W,
    parameter int TIDW        = `MMM_TID_W,
    parameter int LATW        = `MMM_LAT_W,
    parameter int CQL         = `MMM_CMD_DEPTH_LOG,
    parameter int RQL         = `MMM_RSP_DEPTH_LOG,
    parameter int MAX_PEND_RD = `MMM_MAX_PEND_READS,
    parameter int FIXED_RL    = `MMM_FIXED_RD_LAT,
    parameter int FIXED_RW    = `MMM_FIXED_RD_WAIT,
    parameter int FIXED_WW    = `MMM_FIXED_WR_WAIT,
    parameter bit USE_READ    = 1'b1,
    parameter bit USE_WRITE   = 1'b1,
    parameter bit USE_ADDR    = 1'b1,
    parameter bit USE_BE      = 1'b1,
    parameter bit USE_BURST   = 1'b1,
    parameter bit USE_RDATA   = 1'b1,
    parameter bit USE_RDVALID = 1'b1,
    parameter bit USE_WDATA   = 1'b1,
    parameter bit USE_WAIT    = 1'b1,
    parameter bit USE_BEGIN   = 1'b0,
    parameter bit USE_BBEGIN  = 1'b0,
    parameter bit USE_ARBLOCK = 1'b0,
    parameter bit USE_LOCK    = 1'b0,
    parameter bit USE_DEBUG   = 1'b0,
    parameter bit USE_TID     = 1'b0,
    parameter bit USE_RSTAT   = 1'b0,
    parameter bit WAIT_HIGH   = 1'b1,
    parameter bit READ_HIGH   = 1'b1,
    parameter bit WRITE_HIGH  = 1'b1,
    parameter bit BE_HIGH     = 1'b1,
    parameter bit RDV_HIGH    = 1'b1,
    parameter bit ARB_HIGH    = 1'b1,
    parameter bit LOCK_HIGH   = 1'b1,
    parameter bit WRAP_BURST  = 1'b1,
    parameter bit ALIGN_BURST = 1'b1,
    parameter bit REG_WAIT    = 1'b0,
    parameter bit REG_INPUTS  = 1'b0,
    parameter bit ADDR_SYMBOL = 1'b0
) (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 clken,
    input  wire logic                 cmd_push,
    input  wire logic                 cmd_is_write,
    input  wire logic [AW-1:0]        cmd_addr,
    input  wire logic [BW-1:0]        cmd_len,
    input  wire logic [TIDW-1:0]      cmd_tag,
    input  wire logic                 cmd_lock,
    input  wire logic                 cmd_debug,
    input  wire logic                 beat_push,
    input  wire logic [NSYM*SYMW-1:0] beat_data,
    input  wire logic [NSYM-1:0]      beat_be,
    input  wire logic                 rsp_pop,
    input  wire logic [BW-1:0]        rsp_index,
    output logic                      cmd_full,
    output logic                      beat_full,
    output logic [CQL:0]              pending_count,
    output logic [1:0]                issued_count,
    output logic [RQL:0]              rsp_count,
    output logic [RQL:0]              read_rsp_count,
    output logic                      all_done,
    output logic [1:0]                rsp_type,
    output logic [AW-1:0]             rsp_addr,
    output logic [BW-1:0]             rsp_len,
    output logic [TIDW-1:0]           rsp_tag,
    output logic [NSYM-1:0]           rsp_be,
    output logic [NSYM*SYMW-1:0]      rsp_data,
    output logic [LATW-1:0]           rsp_latency,
    output logic [RSW-1:0]            rsp_status,
    output logic [AW-1:0]             bus_address,
    output logic                      bus_read,
    output logic                      bus_write,
    output logic [NSYM-1:0]           bus_byteenable,
    output logic [BW-1:0]             bus_burstcount,
    output logic [NSYM*SYMW-1:0]      bus_writedata,
    output logic                      bus_begintransfer,
    output logic                      bus_beginbursttransfer,
    output logic                      bus_arbiterlock,
    output logic                      bus_lock,
    output logic                      bus_debugaccess,
    output logic [TIDW-1:0]           bus_transactionid,
    input  wire logic [NSYM*SYMW-1:0] bus_readdata,
    input  wire logic                 bus_readdatavalid,
    input  wire logic                 bus_waitrequest,
    input  wire logic [RSW-1:0]       bus_response
);
    localparam int DW   = NSYM * SYMW;
    localparam int MAXB = 2 ** (BW - 1);
    localparam int SSH  = $clog2(NSYM);
    localparam int CQD  = 2 ** CQL;
    localparam int RQD  = 2 ** RQL;
    localparam int BQL  = CQL + BW - 1;

    typedef struct packed {
        mmm_state_type      state;
        logic [CQL:0]       cq_wr;
        logic [CQL:0]       cq_rd;
        logic [BQL:0]       bq_wr;
        logic [BQL:0]       bq_rd;
        logic [RQL:0]       hq_wr;
        logic [RQL:0]       hq_rd;
        logic [RQL:0]       rd_cnt;
        logic [RQL:0]       n_rsp;
        logic               cur_wr;
        logic [AW-1:0]      cur_base;
        logic [AW-1:0]      cur_mask;
        logic [BW-1:0]      cur_len;
        logic [TIDW-1:0]    cur_tag;
        logic [BW-1:0]      beat;
        logic [LATW-1:0]    lat;
        logic [LATW-1:0]    wcnt;
        logic               in_wait;
        logic               in_rdv;
        logic [DW-1:0]      in_rdata;
        logic [RSW-1:0]     in_stat;
        logic [AW-1:0]      address;
        logic               rd;
        logic               wr;
        logic [NSYM-1:0]    be;
        logic [BW-1:0]      burst;
        logic [DW-1:0]      wdata;
        logic               begin_x;
        logic               bbegin;
        logic               arblock;
        logic               lock;
        logic               debug;
        logic [TIDW-1:0]    tid;
        logic               c_full;
        logic               b_full;
        logic [CQL:0]       pend;
        logic [1:0]         issued;
        logic               done;
        logic [RQL-1:0]     o_slot;
        logic [1:0]         o_type;
        logic [AW-1:0]      o_addr;
        logic [BW-1:0]      o_len;
        logic [TIDW-1:0]    o_tag;
        logic [NSYM-1:0]    o_be;
        logic [DW-1:0]      o_data;
        logic [LATW-1:0]    o_lat;
        logic [RSW-1:0]     o_stat;
    } mmm_regs_type;

    mmm_regs_type s;
    mmm_regs_type next_s;

    logic                 cq_wr_n    [CQD];
    logic [AW-1:0]        cq_addr    [CQD];
    logic [BW-1:0]        cq_len     [CQD];
    logic [TIDW-1:0]      cq_tag     [CQD];
    logic                 cq_lock    [CQD];
    logic                 cq_dbg     [CQD];
    logic [DW-1:0]        bq_data    [CQD*MAXB];
    logic [NSYM-1:0]      bq_be      [CQD*MAXB];
    logic [1:0]           hq_type    [RQD];
    logic [AW-1:0]        hq_addr    [RQD];
    logic [BW-1:0]        hq_len     [RQD];
    logic [TIDW-1:0]      hq_tag     [RQD];
    logic [DW-1:0]        rb_data    [RQD*MAXB];
    logic [NSYM-1:0]      rb_be      [RQD*MAXB];
    logic [LATW-1:0]      rb_lat     [RQD*MAXB];
    logic [RSW-1:0]       rb_stat    [RQD*MAXB];

    logic                 cq_we;
    logic                 bq_we;
    logic                 rb_we;
    logic                 hq_we;
    logic [RQL+BW-2:0]    rb_idx;

    // Physical pin level for a logical value
    function automatic logic pin(input logic v, input logic high, input logic used);
        return used & v ? high : ~high;
    endfunction

    // Low-order mask covering the burst, rounded up to a power of two
    function automatic logic [AW-1:0] burst_mask(input logic [BW-1:0] len);
        logic [AW-1:0] m;
        m = '0;
        for (int i = 0; i < BW; i++) begin
            if (len > (BW'(1) << i)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Word address of a burst cycle, scaled to pin units
    function automatic logic [AW-1:0] beat_addr(input logic [AW-1:0] base,
                                                input logic [AW-1:0] mask,
                                                input logic [BW-1:0] i);
        logic [AW-1:0] w;
        w = base + AW'(i);
        if (WRAP_BURST) begin
            w = (base & ~mask) | (w & mask);
        end
        return ADDR_SYMBOL ? (w << SSH) : w;
    endfunction

    always_comb begin
        logic            stalled;
        logic            rd_beat;
        logic            wr_acc;
        logic            last;
        logic            pop_ok;
        logic            start;
        logic [BW-1:0]   len;
        logic [AW-1:0]   base;
        logic [AW-1:0]   mask;
        logic [CQL-1:0]  ci;
        logic [BQL:0]    bavail;
        logic [BQL-1:0]  bi;
        next_s  = s;
        stalled = 1'b0;
        rd_beat = 1'b0;
        wr_acc  = 1'b0;
        ci      = s.cq_rd[CQL-1:0];
        bi      = s.bq_rd[BQL-1:0];
        len     = (cq_len[ci] == '0) ? BW'(1) : cq_len[ci];
        if (len > BW'(MAXB)) begin
            len = BW'(MAXB);
        end
        mask    = burst_mask(len);
        base    = ADDR_SYMBOL ? (cq_addr[ci] >> SSH) : cq_addr[ci];
        if (ALIGN_BURST) begin
            base = base & ~mask;
        end
        bavail  = s.bq_wr - s.bq_rd;
        last    = (s.beat == s.cur_len - BW'(1));
        pop_ok  = rsp_pop && (s.hq_wr != s.hq_rd);
        start   = 1'b0;
        cq_we   = cmd_push && !s.c_full;
        bq_we   = beat_push && !s.b_full;
        rb_we   = 1'b0;
        hq_we   = 1'b0;
        rb_idx  = {s.hq_wr[RQL-1:0], s.beat[BW-2:0]};

        // Incoming stages, optionally registered
        next_s.in_wait  = (bus_waitrequest == WAIT_HIGH);
        next_s.in_rdv   = (bus_readdatavalid == RDV_HIGH);
        next_s.in_rdata = bus_readdata;
        next_s.in_stat  = bus_response;

        if (cq_we) begin
            next_s.cq_wr = s.cq_wr + 1'b1;
        end
        if (bq_we) begin
            next_s.bq_wr = s.bq_wr + 1'b1;
        end
        next_s.begin_x = pin(1'b0, 1'b1, USE_BEGIN);
        next_s.bbegin  = pin(1'b0, 1'b1, USE_BBEGIN);

        case (s.state)
            mmm_st_idle: begin
                // Head command leaves only once all its cycles are queued
                if (s.cq_wr != s.cq_rd && bavail >= (BQL+1)'(len) &&
                    (s.hq_wr - s.hq_rd) != (RQL+1)'(RQD)) begin
                    start          = 1'b1;
                    next_s.cq_rd   = s.cq_rd + 1'b1;
                    next_s.cur_wr  = cq_wr_n[ci];
                    next_s.cur_base = base;
                    next_s.cur_mask = mask;
                    next_s.cur_len = len;
                    next_s.cur_tag = cq_tag[ci];
                    next_s.beat    = '0;
                    next_s.wcnt    = '0;
                    next_s.address = pin(1'b1, 1'b1, USE_ADDR) ?
                                     beat_addr(base, mask, '0) : '0;
                    next_s.rd      = pin(!cq_wr_n[ci], READ_HIGH, USE_READ);
                    next_s.wr      = pin(cq_wr_n[ci], WRITE_HIGH, USE_WRITE);
                    next_s.be      = USE_BE ? (bq_be[bi] ^ {NSYM{~BE_HIGH}}) : '0;
                    next_s.burst   = USE_BURST ? len : '0;
                    next_s.wdata   = USE_WDATA ? bq_data[bi] : '0;
                    next_s.begin_x = pin(1'b1, 1'b1, USE_BEGIN);
                    next_s.bbegin  = pin(1'b1, 1'b1, USE_BBEGIN);
                    next_s.arblock = pin(cq_lock[ci] && len == BW'(1), ARB_HIGH, USE_ARBLOCK);
                    next_s.lock    = pin(cq_lock[ci] && len == BW'(1), LOCK_HIGH, USE_LOCK);
                    next_s.debug   = pin(cq_dbg[ci], 1'b1, USE_DEBUG);
                    next_s.tid     = USE_TID ? cq_tag[ci] : '0;
                    next_s.state   = mmm_st_req;
                end
            end
            mmm_st_req: begin
                if (USE_WAIT) begin
                    stalled = REG_WAIT ? s.in_wait : (bus_waitrequest == WAIT_HIGH);
                end else begin
                    stalled = s.wcnt < LATW'(s.cur_wr ? FIXED_WW : FIXED_RW);
                end
                if (stalled) begin
                    next_s.wcnt = s.wcnt + 1'b1;
                end else if (s.cur_wr) begin
                    wr_acc        = 1'b1;
                    next_s.wcnt   = '0;
                    next_s.bq_rd  = s.bq_rd + 1'b1;
                    if (last) begin
                        next_s.wr    = pin(1'b0, WRITE_HIGH, USE_WRITE);
                        next_s.lock  = pin(1'b0, LOCK_HIGH, USE_LOCK);
                        next_s.arblock = pin(1'b0, ARB_HIGH, USE_ARBLOCK);
                        next_s.state = mmm_st_idle;
                    end else begin
                        next_s.beat    = s.beat + 1'b1;
                        next_s.address = USE_ADDR ?
                                         beat_addr(s.cur_base, s.cur_mask, s.beat + 1'b1) : '0;
                        next_s.be      = USE_BE ? (bq_be[bi + 1'b1] ^ {NSYM{~BE_HIGH}}) : '0;
                        next_s.wdata   = USE_WDATA ? bq_data[bi + 1'b1] : '0;
                        next_s.begin_x = pin(1'b1, 1'b1, USE_BEGIN);
                    end
                end else begin
                    // One outstanding read at a time keeps within the slave's limit
                    next_s.rd    = pin(1'b0, READ_HIGH, USE_READ);
                    next_s.lat   = LATW'(1);
                    next_s.state = mmm_st_resp;
                end
            end
            mmm_st_resp: begin
                next_s.lat = s.lat + 1'b1;
                if (USE_RDVALID) begin
                    rd_beat = REG_INPUTS ? s.in_rdv : (bus_readdatavalid == RDV_HIGH);
                end else begin
                    rd_beat = s.lat >= LATW'(FIXED_RL);
                end
                if (rd_beat) begin
                    next_s.bq_rd = s.bq_rd + 1'b1;
                    if (last) begin
                        next_s.lock    = pin(1'b0, LOCK_HIGH, USE_LOCK);
                        next_s.arblock = pin(1'b0, ARB_HIGH, USE_ARBLOCK);
                        next_s.state   = mmm_st_idle;
                    end else begin
                        next_s.beat = s.beat + 1'b1;
                    end
                end
            end
            default: begin
                next_s.state = mmm_st_idle;
            end
        endcase

        rb_we = wr_acc || rd_beat;
        hq_we = rb_we && last;
        if (hq_we) begin
            next_s.hq_wr = s.hq_wr + 1'b1;
        end
        if (pop_ok) begin
            next_s.hq_rd  = s.hq_rd + 1'b1;
            next_s.o_slot = s.hq_rd[RQL-1:0];
            next_s.o_type = hq_type[s.hq_rd[RQL-1:0]];
            next_s.o_addr = hq_addr[s.hq_rd[RQL-1:0]];
            next_s.o_len  = hq_len[s.hq_rd[RQL-1:0]];
            next_s.o_tag  = hq_tag[s.hq_rd[RQL-1:0]];
        end
        next_s.rd_cnt = s.rd_cnt + (RQL+1)'(hq_we && !s.cur_wr)
                        - (RQL+1)'(pop_ok && hq_type[s.hq_rd[RQL-1:0]] == `MMM_CMD_READ);
        next_s.o_be   = rb_be[{next_s.o_slot, rsp_index[BW-2:0]}];
        next_s.o_data = rb_data[{next_s.o_slot, rsp_index[BW-2:0]}];
        next_s.o_lat  = rb_lat[{next_s.o_slot, rsp_index[BW-2:0]}];
        next_s.o_stat = rb_stat[{next_s.o_slot, rsp_index[BW-2:0]}];

        next_s.pend   = next_s.cq_wr - next_s.cq_rd;
        next_s.n_rsp  = next_s.hq_wr - next_s.hq_rd;
        next_s.issued = (next_s.state != mmm_st_idle) ? 2'h1 : 2'h0;
        next_s.done   = (next_s.pend == '0) && (next_s.state == mmm_st_idle) && !start;
        next_s.c_full = next_s.pend == (CQL+1)'(CQD);
        next_s.b_full = (next_s.bq_wr - next_s.bq_rd) == (BQL+1)'(CQD*MAXB);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s         <= '0;
            s.state   <= mmm_st_idle;
            s.rd      <= ~READ_HIGH;
            s.wr      <= ~WRITE_HIGH;
            s.be      <= {NSYM{~BE_HIGH}};
            s.arblock <= ~ARB_HIGH;
            s.lock    <= ~LOCK_HIGH;
            s.done    <= 1'b1;
            s.o_type  <= `MMM_CMD_IDLE;
        end else if (clken) begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk) begin
        if (clken) begin
            if (cq_we) begin
                cq_wr_n[s.cq_wr[CQL-1:0]] <= cmd_is_write;
                cq_addr[s.cq_wr[CQL-1:0]] <= cmd_addr;
                cq_len[s.cq_wr[CQL-1:0]]  <= cmd_len;
                cq_tag[s.cq_wr[CQL-1:0]]  <= cmd_tag;
                cq_lock[s.cq_wr[CQL-1:0]] <= cmd_lock;
                cq_dbg[s.cq_wr[CQL-1:0]]  <= cmd_debug;
            end
            if (bq_we) begin
                bq_data[s.bq_wr[BQL-1:0]] <= beat_data;
                bq_be[s.bq_wr[BQL-1:0]]   <= beat_be;
            end
            if (rb_we) begin
                rb_be[rb_idx]   <= bq_be[s.bq_rd[BQL-1:0]];
                rb_data[rb_idx] <= s.cur_wr ? s.wdata :
                                   (REG_INPUTS ? s.in_rdata : bus_readdata);
                rb_lat[rb_idx]  <= s.cur_wr ? '0 : s.lat;
                rb_stat[rb_idx] <= (s.cur_wr || !USE_RSTAT) ? '0 :
                                   (REG_INPUTS ? s.in_stat : bus_response);
            end
            if (hq_we) begin
                hq_type[s.hq_wr[RQL-1:0]] <= s.cur_wr ? `MMM_CMD_WRITE : `MMM_CMD_READ;
                hq_addr[s.hq_wr[RQL-1:0]] <= ADDR_SYMBOL ? (s.cur_base << SSH) : s.cur_base;
                hq_len[s.hq_wr[RQL-1:0]]  <= s.cur_len;
                hq_tag[s.hq_wr[RQL-1:0]]  <= s.cur_tag;
            end
        end
    end

    assign cmd_full               = s.c_full;
    assign beat_full              = s.b_full;
    assign pending_count          = s.pend;
    assign issued_count           = s.issued;
    assign rsp_count              = s.n_rsp;
    assign read_rsp_count         = s.rd_cnt;
    assign all_done               = s.done;
    assign rsp_type               = s.o_type;
    assign rsp_addr               = s.o_addr;
    assign rsp_len                = s.o_len;
    assign rsp_tag                = s.o_tag;
    assign rsp_be                 = s.o_be;
    assign rsp_data               = s.o_data;
    assign rsp_latency            = s.o_lat;
    assign rsp_status             = s.o_stat;
    assign bus_address            = s.address;
    assign bus_read               = s.rd;
    assign bus_write              = s.wr;
    assign bus_byteenable         = s.be;
    assign bus_burstcount         = s.burst;
    assign bus_writedata          = s.wdata;
    assign bus_begintransfer      = s.begin_x;
    assign bus_beginbursttransfer = s.bbegin;
    assign bus_arbiterlock        = s.arblock;
    assign bus_lock               = s.lock;
    assign bus_debugaccess        = s.debug;
    assign bus_transactionid      = s.tid;

endmodule

// ---- src/mmm_params.svh ----
`ifndef MMM_PARAMS_SVH
`define MMM_PARAMS_SVH

// Default configuration values
`define MMM_ADDR_W          32
`define MMM_SYMBOL_W        8
`define MMM_NUM_SYMBOLS     4
`define MMM_BURST_W         3
`define MMM_RESP_W          8
`define MMM_TID_W           8
`define MMM_LAT_W           16
`define MMM_MAX_PEND_READS  1
`define MMM_FIXED_RD_LAT    1
`define MMM_FIXED_RD_WAIT   1
`define MMM_FIXED_WR_WAIT   0
`define MMM_CMD_DEPTH_LOG   3
`define MMM_RSP_DEPTH_LOG   2

// Command type encodings in the response descriptor
`define MMM_CMD_READ        2'h0
`define MMM_CMD_WRITE       2'h1
`define MMM_CMD_IDLE        2'h2

`endif

// ---- src/mmm_pkg.sv ----
package mmm_pkg;

    typedef enum logic [1:0] {
        cmd_type_read  = 2'h0,
        cmd_type_write = 2'h1,
        cmd_type_idle  = 2'h2
    } mmm_cmd_type;

    // Gray sequence idle -> request -> response
    typedef enum logic [1:0] {
        mmm_st_idle = 2'h0,
        mmm_st_req  = 2'h1,
        mmm_st_resp = 2'h3
    } mmm_state_type;

endpackage

// ---- test/mmm_checker.sv ----
`timescale 1ns/10ps
module mmm_checker (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        clken,
    input wire logic        cmd_push,
    input wire logic        cmd_full,
    input wire logic [3:0]  pending_count,
    input wire logic [1:0]  issued_count,
    input wire logic        all_done,
    input wire logic        rsp_pop,
    input wire logic [2:0]  rsp_count,
    input wire logic [1:0]  rsp_type,
    input wire logic [31:0] bus_address,
    input wire logic [31:0] bus_writedata,
    input wire logic [3:0]  bus_byteenable,
    input wire logic [2:0]  bus_burstcount,
    input wire logic        bus_read,
    input wire logic        bus_write,
    input wire logic        bus_waitrequest
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    rd_hold_a: assert property (bus_read && bus_waitrequest |=>
        bus_read && $stable(bus_address)) else $error("read changed while stalled");
    wr_hold_a: assert property (bus_write && bus_waitrequest |=>
        bus_write && $stable(bus_writedata)) else $error("write changed while stalled");
    lanes_hold_a: assert property (bus_write && bus_waitrequest |=>
        $stable(bus_byteenable) && $stable(bus_burstcount)) else $error("lanes changed while stalled");
    busy_done_a: assert property (bus_read || bus_write |-> !all_done)
        else $error("done while bus busy");
    one_dir_a: assert property (!(bus_read && bus_write))
        else $error("read and write together");
    rd_once_a: assert property (bus_read && !bus_waitrequest |=> !bus_read)
        else $error("read held after accept");
    issued_a: assert property (bus_read || bus_write |-> issued_count == 2'h1)
        else $error("issued count wrong");
    pend_a: assert property (clken && cmd_push && !cmd_full |=> pending_count != 4'h0)
        else $error("pushed command not counted");
    pop_type_a: assert property (clken && rsp_pop && rsp_count != 3'h0 |=>
        rsp_type != 2'h2) else $error("popped type idle");
    cover property (bus_read && !bus_waitrequest);
    cover property (bus_write && bus_waitrequest);
    cover property (rsp_pop && rsp_count != 3'h0);
endmodule
bind mmm_master mmm_checker u_chk (.*);

// ---- test/mmm_slave_model.sv ----
`timescale 1ns/10ps
module mmm_slave_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        slow,
    input  wire logic [31:0] bus_address,
    input  wire logic        bus_read,
    input  wire logic        bus_write,
    input  wire logic [31:0] bus_writedata,
    output logic [31:0]      bus_readdata,
    output logic             bus_readdatavalid,
    output logic             bus_waitrequest
);
    logic [31:0] mem [16];
    logic [3:0]  ra;
    logic        pend;
    logic        tick;
    assign bus_readdatavalid = pend;
    // Idle data toggles so stale values never look valid
    assign bus_readdata = pend ? mem[ra] : {32{tick}};
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend <= 1'b0;
            tick <= 1'b0;
            bus_waitrequest <= 1'b0;
            for (int i = 0; i < 16; i++) mem[i] <= 32'h0;
        end else begin
            tick <= ~tick;
            bus_waitrequest <= slow && !bus_waitrequest;
            pend <= bus_read && !bus_waitrequest && !pend;
            if (bus_read && !bus_waitrequest) ra <= bus_address[3:0];
            if (bus_write && !bus_waitrequest) mem[bus_address[3:0]] <= bus_writedata;
        end
    end
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    logic        clk, resetn, slow, cmd_push, cmd_is_write, beat_push, rsp_pop, all_done;
    logic        bus_read, bus_write, bus_readdatavalid, bus_waitrequest, cmd_full, beat_full;
    logic [1:0]  issued_count, rsp_type;
    logic [2:0]  cmd_len, rsp_index, rsp_count, read_rsp_count, rsp_len;
    logic [3:0]  beat_be, rsp_be, pending_count;
    logic [7:0]  cmd_tag, rsp_tag, rsp_status;
    logic [15:0] rsp_latency;
    logic [31:0] cmd_addr, beat_data, rsp_addr, rsp_data, bus_address, bus_writedata;
    logic [31:0] bus_readdata, mem [16], d [4], r;
    int          seed, err_count, cmp_count;
    mmm_master dut (.*, .clken(1'b1), .cmd_lock(1'b0), .cmd_debug(1'b0), .bus_response(8'h0),
        .bus_byteenable(), .bus_burstcount(),
        .bus_begintransfer(), .bus_beginbursttransfer(), .bus_arbiterlock(), .bus_lock(),
        .bus_debugaccess(), .bus_transactionid());
    mmm_slave_model slv (.*);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function logic [3:0] wrap(logic [3:0] a, logic [2:0] n, int i);
        logic [3:0] m;
        m = 4'(n) - 4'h1;
        return (a & ~m) | ((a + 4'(i)) & m);
    endfunction
    task run(input logic w, input logic [3:0] a, input logic [2:0] n);
        int t;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            d[i] = $random(seed);
            cmd_push = (i == 0);
            {cmd_is_write, cmd_addr, cmd_len, cmd_tag} = {w, 28'h0, a, n, d[0][15:8]};
            {beat_push, beat_data, beat_be} = {1'b1, d[i], d[i][3:0]};
            if (w) mem[wrap(a, n, i)] = d[i];
        end
        @(negedge clk);
        {cmd_push, beat_push} = 2'h0;
        for (t = 0; rsp_count == 3'h0 && t < 200; t++) @(negedge clk);
        if (t == 200) begin
            err_count++;
            summarize();
        end
        chk(read_rsp_count, !w);
        chk(all_done, 1);
        {rsp_pop, rsp_index} = {1'b1, 3'h0};
        @(negedge clk);
        rsp_pop = 1'b0;
        chk(rsp_count, 0);
        chk(read_rsp_count, 0);
        chk({cmd_full, beat_full}, 0);
        @(negedge clk);
        chk(rsp_type, w);
        chk(rsp_addr, {28'h0, a});
        chk(rsp_len, n);
        if (!w) chk(rsp_tag, d[0][15:8]);
        for (int i = 0; i < n; i++) begin
            rsp_index = 3'(i);
            @(negedge clk);
            chk(rsp_data, w ? d[i] : mem[a]);
            chk(rsp_be, d[i][3:0]);
            chk(rsp_latency, !w);
            chk(rsp_status, 0);
        end
        chk({pending_count, issued_count}, 0);
        $display("test end: write %0d addr %h len %0d", w, a, n);
    endtask
    initial begin
        {seed, err_count, cmp_count} = {32'h6853, 64'h0};
        {resetn, slow, cmd_push, cmd_is_write, beat_push, rsp_pop} = 6'h0;
        {cmd_addr, cmd_len, cmd_tag, beat_data, beat_be, rsp_index} = 0;
        for (int i = 0; i < 16; i++) mem[i] = 32'h0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        chk({rsp_type, all_done}, 3'h5);
        run(1'b1, 4'h4, 3'h4);
        run(1'b0, 4'h6, 3'h1);
        for (int k = 0; k < 40; k++) begin
            r = $random(seed);
            slow = r[8];
            cmd_len = r[0] ? (r[2] ? 3'h4 : (r[3] ? 3'h2 : 3'h1)) : 3'h1;
            run(r[0], r[7:4] & ~(4'(cmd_len) - 4'h1), cmd_len);
        end
        summarize();
    end
endmodule
